// File: fic_pkg.sv
// Purpose: shared constants for the four-level interrupt controller
// Assumes: 32-bit apb, one register per aligned word
// Notes:   source numbering follows vector order, source 0 ranks first
package fic_pkg;
  localparam int          NUM_SRC      = 16;
  localparam int          NUM_LVL      = 4;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam logic [15:0] VEC_STEP     = 16'h0008;
  localparam logic [15:0] VEC_RESET    = 16'h0000;
  // response time, least, in ns and in cycles at 250 MHz
  localparam int          RESP_NS      = 16;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          RESP_CYC     = (RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0]  OFS_EN_A     = 8'h00;
  localparam logic [7:0]  OFS_EN_B     = 8'h04;
  localparam logic [7:0]  OFS_PL_A     = 8'h08;
  localparam logic [7:0]  OFS_PH_A     = 8'h0C;
  localparam logic [7:0]  OFS_PL_B     = 8'h10;
  localparam logic [7:0]  OFS_PH_B     = 8'h14;
  localparam logic [7:0]  OFS_FLAGS    = 8'h18;
  localparam logic [7:0]  OFS_TRIG     = 8'h1C;
  localparam logic [7:0]  OFS_STATUS   = 8'h20;
  // field positions
  localparam int          BIT_GIE      = 7;
  localparam int          SRC_EXT_A    = 0;
  localparam int          SRC_TMR_A    = 1;
  localparam int          SRC_EXT_B    = 2;
  localparam int          SRC_TMR_B    = 3;
  localparam int          SRC_SER      = 4;
  localparam int          SRC_TMR_C    = 5;
  localparam int          SRC_KEY      = 7;
  localparam int          SRC_EE       = 11;
  localparam int          SRC_CMP      = 12;
  localparam int          SRC_WDT      = 15;
  // sources whose flag hardware clears on vectoring (ext handled by mode)
  localparam logic [15:0] AUTO_CLR_MASK = 16'h980A;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_SAVE, ST_LOAD} fic_state_t;
endpackage

// File: fic_top.sv
// Purpose: interrupt flags, arbitration and vectored call sequencing
// Assumes: core strobes instruction boundaries; inputs synchronous to pclk
// Notes:   all state in one packed struct, apb answers with zero wait states
//          register map, one aligned word each, upper bits read as zero:
//            00 enable a: bit 7 global, bits 0-5 sources 0-5, bit 6 source 14
//            04 enable b: bits 0-6 serve sources 6, 8, 12, 10, 7, 9 and 13
//               bit 7 serves source 11 and source 15 together
//            08 level low bits a, 0C level high bits a, same bit order as enable a
//            10 level low bits b, 14 level high bits b, same bit order as enable b
//               except that bit 7 of the a pair sets the level of source 11
//            18 request flags, bit n for source n
//            1C trigger type of pins a and b, a one selects edge mode
//            20 status: last granted level in bits 5:4, in-service levels in 3:0
//          level-mode pin flags mirror the pin, so software writes to them are lost
//          a level change takes two writes; keep the source disabled meanwhile
//          unmapped offsets read zero and ignore writes; no error is raised
//
// Our own choices: the register addresses and register access over APB.
module fic_top
  import fic_pkg::*;
(
  input  wire logic                 pclk,           // system clock
  input  wire logic                 presetn,        // async reset, low
  input  wire logic                 clk_en,         // freezes state when low
  input  wire logic                 psel,           // apb select
  input  wire logic                 penable,        // apb access phase
  input  wire logic                 pwrite,         // apb direction
  input  wire logic [7:0]           paddr,          // apb byte address
  input  wire logic [31:0]          pwdata,         // apb write data
  output logic      [31:0]          prdata,         // apb read data
  output logic                      pready,         // apb ready
  output logic                      pslverr,        // apb error
  input  wire logic                 ext_irq_pin_a,  // external pin a
  input  wire logic                 ext_irq_pin_b,  // external pin b
  input  wire logic [fic_pkg::NUM_SRC-1:0] hw_set,  // peripheral set pulses
  input  wire logic                 key_released,   // keypad release level
  input  wire logic                 instr_last,     // last cycle of instruction
  input  wire logic                 instr_reti,     // that instruction is reti
  input  wire logic                 instr_cfg,      // it touches enable/prio
  output logic                      call_req,       // ack: core starts call
  output logic                      push_pc,        // save pc, no status word
  output logic                      load_pc,        // load vector into pc
  output logic      [15:0]          vector_addr,    // vector for load
  output logic      [fic_pkg::NUM_LVL-1:0] in_service // levels in service
);
  import fic_pkg::*;

  // every register of the block lives in this one struct
  typedef struct packed {
    logic [7:0]  en_a;
    logic [7:0]  en_b;
    logic [7:0]  pl_a;
    logic [7:0]  ph_a;
    logic [7:0]  pl_b;
    logic [7:0]  ph_b;
    logic [15:0] flags;
    logic [1:0]  trig;
    logic [1:0]  pin_smp;
    logic [3:0]  isr;
    logic        hold;
    fic_state_t  st;
    logic [3:0]  win;
    logic [1:0]  win_lvl;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        call;
    logic        push;
    logic        load;
    logic [15:0] vec;
  } fic_regs_t;

  // current state and the value it takes at the next enabled edge
  fic_regs_t cur_ff;
  fic_regs_t nxt_ff;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // index of highest set in-service bit, used by reti and blocking
  function automatic logic [1:0] top_level(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // enable bit per source; enable b bit 7 serves both source 11 and source 15
  function automatic logic src_en(input fic_regs_t s, input int k);
    logic e;
    e = 1'b0;
    case (k)
      0, 1, 2, 3, 4, 5: e = s.en_a[k];
      14:               e = s.en_a[6];
      6:                e = s.en_b[0];
      8:                e = s.en_b[1];
      12:               e = s.en_b[2];
      10:               e = s.en_b[3];
      7:                e = s.en_b[4];
      9:                e = s.en_b[5];
      13:               e = s.en_b[6];
      11:               e = s.en_b[7];
      default:          e = s.en_b[7];
    endcase
    return e;
  endfunction

  // priority bits per source; same mapping as enables except ee (source 11)
  // source 11 takes its level from bit 7 of the a pair
  function automatic logic [1:0] src_lvl(input fic_regs_t s, input int k);
    logic [1:0] l;
    l = 2'h0;
    case (k)
      0, 1, 2, 3, 4, 5: l = {s.ph_a[k], s.pl_a[k]};
      14:               l = {s.ph_a[6], s.pl_a[6]};
      11:               l = {s.ph_a[7], s.pl_a[7]};
      6:                l = {s.ph_b[0], s.pl_b[0]};
      8:                l = {s.ph_b[1], s.pl_b[1]};
      12:               l = {s.ph_b[2], s.pl_b[2]};
      10:               l = {s.ph_b[3], s.pl_b[3]};
      7:                l = {s.ph_b[4], s.pl_b[4]};
      9:                l = {s.ph_b[5], s.pl_b[5]};
      13:               l = {s.ph_b[6], s.pl_b[6]};
      default:          l = {s.ph_b[7], s.pl_b[7]};
    endcase
    return l;
  endfunction

  // vector slot: base plus one step per source number; slots past 15 unused
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    logic [15:0] v;
    v = VEC_BASE + VEC_STEP * {12'h0, s};
    return v;
  endfunction

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] active;
  logic [1:0]         lvl [NUM_SRC];
  logic               found;
  logic [3:0]         pick;
  logic [1:0]         pick_lvl;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      // flag gated by own enable and global enable
      assign active[g] = cur_ff.flags[g] & src_en(cur_ff, g)
                         & cur_ff.en_a[BIT_GIE];
      assign lvl[g]    = src_lvl(cur_ff, g);
    end
  endgenerate

  // highest level wins, lowest source number within a level; scanning down
  // lets a lower number overwrite an equal-level pick, so source 0 ranks first
  always_comb begin
    found    = 1'b0;
    pick     = 4'h0;
    pick_lvl = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (active[i] && (!found || lvl[i] >= pick_lvl)) begin
        found    = 1'b1;
        pick     = 4'(i);
        pick_lvl = lvl[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic       wr_acc;
  logic       rd_acc;
  logic       grant;
  logic       lvl_free;
  logic       poll_ok;
  logic       no_block;
  logic [15:0] sw_flags;

  // write lands on the access edge, read is captured on the setup edge
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  // nothing of equal or higher level in service; top level blocks everything
  assign lvl_free = (cur_ff.isr == 4'h0) || (pick_lvl > top_level(cur_ff.isr));
  // poll only in the last cycle of an instruction, with no call walk running
  assign poll_ok  = instr_last && (cur_ff.st == ST_IDLE);
  // no return, no config access, and the one-instruction lockout is spent
  assign no_block = !instr_reti && !instr_cfg && !cur_ff.hold;
  // requests are not latched: a flag that has gone loses its turn
  assign grant    = found && lvl_free && poll_ok && no_block;

  always_comb begin
    // every field holds by default; the strobes last one cycle
    nxt_ff      = cur_ff;
    nxt_ff.ready = 1'b0;
    nxt_ff.err  = 1'b0;
    nxt_ff.call = 1'b0;
    nxt_ff.push = 1'b0;
    nxt_ff.load = 1'b0;
    sw_flags    = cur_ff.flags;

    // apb: zero-wait answer in the access phase
    if (psel && !penable) begin
      nxt_ff.ready = 1'b1;
    end
    // read data is taken in setup so it stands through the access cycle
    if (rd_acc) begin
      case (paddr)
        OFS_EN_A:   nxt_ff.rdata = {24'h0, cur_ff.en_a};
        OFS_EN_B:   nxt_ff.rdata = {24'h0, cur_ff.en_b};
        OFS_PL_A:   nxt_ff.rdata = {24'h0, cur_ff.pl_a};
        OFS_PH_A:   nxt_ff.rdata = {24'h0, cur_ff.ph_a};
        OFS_PL_B:   nxt_ff.rdata = {24'h0, cur_ff.pl_b};
        OFS_PH_B:   nxt_ff.rdata = {24'h0, cur_ff.ph_b};
        OFS_FLAGS:  nxt_ff.rdata = {16'h0, cur_ff.flags};
        OFS_TRIG:   nxt_ff.rdata = {30'h0, cur_ff.trig};
        OFS_STATUS: nxt_ff.rdata = {26'h0, cur_ff.win_lvl, cur_ff.isr};
        default:    nxt_ff.rdata = 32'h0;
      endcase
    end
    // unmapped offsets leave every register as it is
    if (wr_acc) begin
      case (paddr)
        OFS_EN_A:  nxt_ff.en_a = pwdata[7:0];
        OFS_EN_B:  nxt_ff.en_b = pwdata[7:0];
        OFS_PL_A:  nxt_ff.pl_a = pwdata[7:0];
        OFS_PH_A:  nxt_ff.ph_a = pwdata[7:0];
        OFS_PL_B:  nxt_ff.pl_b = pwdata[7:0];
        OFS_PH_B:  nxt_ff.ph_b = pwdata[7:0];
        OFS_FLAGS: sw_flags    = pwdata[15:0];
        OFS_TRIG:  nxt_ff.trig = pwdata[1:0];
        default:   nxt_ff.trig = cur_ff.trig;
      endcase
    end

    // flag updates; hardware set wins over every clear except the level-mode pin mirror below
    nxt_ff.pin_smp = {ext_irq_pin_b, ext_irq_pin_a};
    nxt_ff.flags   = sw_flags;
    if (grant) begin
      // ext flags clear only in edge mode, others per auto mask
      nxt_ff.flags[pick] = ~AUTO_CLR_MASK[pick] & sw_flags[pick];
      if ((pick == 4'(SRC_EXT_A) && cur_ff.trig[0])
          || (pick == 4'(SRC_EXT_B) && cur_ff.trig[1])) begin
        nxt_ff.flags[pick] = 1'b0;
      end
    end
    if (key_released) begin
      nxt_ff.flags[SRC_KEY] = 1'b0;
    end
    nxt_ff.flags = nxt_ff.flags | hw_set;
    // edge mode: a high sample followed by a low sample sets the flag,
    // after any clear above, so an edge in the grant cycle is not lost
    if (cur_ff.trig[0]) begin
      if (cur_ff.pin_smp[0] && !ext_irq_pin_a) begin
        nxt_ff.flags[SRC_EXT_A] = 1'b1;
      end
    end else begin
      // level mode: flag mirrors the held-low pin, vectoring leaves it alone
      nxt_ff.flags[SRC_EXT_A] = ~ext_irq_pin_a;
    end
    // pin b works the same way with its own trigger-type bit
    if (cur_ff.trig[1]) begin
      if (cur_ff.pin_smp[1] && !ext_irq_pin_b) begin
        nxt_ff.flags[SRC_EXT_B] = 1'b1;
      end
    end else begin
      nxt_ff.flags[SRC_EXT_B] = ~ext_irq_pin_b;
    end

    // one further instruction must finish after reti or config access
    // hold clears at the next boundary, so that boundary is refused too
    if (instr_last && (instr_reti || instr_cfg)) begin
      nxt_ff.hold = 1'b1;
    end else if (instr_last) begin
      nxt_ff.hold = 1'b0;
    end
    // reti drops only the highest level; a plain return leaves it set
    if (instr_last && instr_reti && cur_ff.isr != 4'h0) begin
      nxt_ff.isr[top_level(cur_ff.isr)] = 1'b0;
    end

    // call sequence: ack, save pc, load vector
    // grants wait in idle until the walk has ended
    case (cur_ff.st)
      ST_IDLE: begin
        if (grant) begin
          nxt_ff.st      = ST_ACK;
          nxt_ff.win     = pick;
          nxt_ff.win_lvl = pick_lvl;
          nxt_ff.call    = 1'b1;
          nxt_ff.isr[pick_lvl] = 1'b1;
        end
      end
      ST_ACK: begin
        // core saves pc without the status word
        nxt_ff.st   = ST_SAVE;
        nxt_ff.push = 1'b1;
      end
      ST_SAVE: begin
        // vector stands together with the load strobe
        nxt_ff.st   = ST_LOAD;
        nxt_ff.load = 1'b1;
        nxt_ff.vec  = vec_of(cur_ff.win);
      end
      ST_LOAD: begin
        nxt_ff.st = ST_IDLE;
      end
      default: begin
        nxt_ff.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // clk_en low freezes every field, pin samples included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff     <= '0;
      cur_ff.st  <= ST_IDLE;
      cur_ff.vec <= VEC_RESET;
      cur_ff.pin_smp <= 2'h3;
    end else if (clk_en) begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from the state register
  // ----------------------------------------------------------------
  // apb side
  assign prdata      = cur_ff.rdata;
  assign pready      = cur_ff.ready;
  assign pslverr     = cur_ff.err;
  // core side: one-cycle strobes of the call walk, vector and levels
  assign call_req    = cur_ff.call;
  assign push_pc     = cur_ff.push;
  assign load_pc     = cur_ff.load;
  assign vector_addr = cur_ff.vec;
  assign in_service  = cur_ff.isr;

endmodule // fic_top

// File: fic_chk_assertions.sv
// Purpose: port-level checks on the interrupt controller
// Assumes: call walk and zero-wait apb timing as handed over
// Notes:   hold_ff mirrors the one-instruction lockout after reti or config
module fic_chk
  import fic_pkg::*;
(
  input wire logic        pclk,        // system clock
  input wire logic        presetn,     // async reset, low
  input wire logic        clk_en,      // state frozen while low
  input wire logic        psel,        // apb select
  input wire logic        penable,     // apb access phase
  input wire logic        pready,      // apb ready
  input wire logic        pslverr,     // apb error
  input wire logic        instr_last,  // instruction boundary
  input wire logic        instr_reti,  // boundary is a return
  input wire logic        instr_cfg,   // boundary touched config
  input wire logic        call_req,    // accept strobe
  input wire logic        push_pc,     // pc save strobe
  input wire logic        load_pc,     // vector load strobe
  input wire logic [15:0] vector_addr, // vector
  input wire logic [3:0]  in_service   // levels in service
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  // a frozen controller answers nothing, so checks rest while clk_en is low
  default disable iff (!presetn || !clk_en);
  logic hold_ff;
  logic nxt_hold;
  // -----------------------------------------------
  // lockout tracker: set by a blocking boundary, spent by the next one
  // -----------------------------------------------
  always_comb begin
    nxt_hold = hold_ff;
    if (instr_last && clk_en) nxt_hold = instr_reti || instr_cfg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_ff <= 1'b0;
    else hold_ff <= nxt_hold;
  end
  property p_seq; call_req |=> push_pc ##1 load_pc; endproperty
  a_seq: assert property (p_seq) else $error("call walk broken");
  property p_load; load_pc |-> $past(call_req, 2) && $past(push_pc); endproperty
  a_load: assert property (p_load) else $error("load without call");
  property p_cause; call_req |-> $past(instr_last && !instr_reti && !instr_cfg); endproperty
  a_cause: assert property (p_cause) else $error("call off boundary");
  property p_hold; call_req |-> !$past(hold_ff); endproperty
  a_hold: assert property (p_hold) else $error("call inside lockout");
  property p_vec; load_pc |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h007B; endproperty
  a_vec: assert property (p_vec) else $error("vector out of table");
  property p_isvc; load_pc |-> in_service != 4'h0; endproperty
  a_isvc: assert property (p_isvc) else $error("no level in service");
  property p_reti;
    instr_last && instr_reti && $onehot(in_service) |-> ##[1:2] in_service == 4'h0;
  endproperty
  a_reti: assert property (p_reti) else $error("return kept level");
  property p_top; in_service[3] && $past(in_service[3]) |-> !call_req; endproperty
  a_top: assert property (p_top) else $error("top level preempted");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer late");
  property p_err; pready |-> !pslverr; endproperty
  a_err: assert property (p_err) else $error("apb error raised");
  c_call: cover property (call_req);
  c_reti: cover property (instr_last && instr_reti);
  c_top: cover property (in_service[3]);
endmodule // fic_chk

bind fic_top fic_chk chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pready, .pslverr,
  .instr_last, .instr_reti, .instr_cfg, .call_req, .push_pc, .load_pc,
  .vector_addr, .in_service);

// File: fic_core_model.sv
// Purpose: core sequencer seen from the controller
// Assumes: bench asks for each instruction boundary with step
// Notes:   qualifiers toggle between boundaries so they must be ignored there
module fic_core_model (
  input  wire logic        pclk,        // system clock
  input  wire logic        presetn,     // async reset, low
  input  wire logic        step,        // bench asks for a boundary
  input  wire logic        reti_i,      // boundary ends a return
  input  wire logic        cfg_i,       // boundary touched config
  input  wire logic        load_pc,     // vector load strobe
  input  wire logic [15:0] vector_addr, // vector
  output logic             instr_last,  // boundary strobe
  output logic             instr_reti,  // return qualifier
  output logic             instr_cfg,   // config qualifier
  output logic [15:0]      pc_ff,       // last loaded pc
  output logic [31:0]      calls_ff     // calls taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------
  // boundary strobe, and pc load on the vector strobe
  // -----------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {instr_last, instr_reti, instr_cfg} <= 3'h0;
      pc_ff <= 16'h0000;
      calls_ff <= 32'h0;
    end else begin
      instr_last <= step;
      instr_reti <= step ? reti_i : !instr_reti;
      instr_cfg <= step ? cfg_i : !instr_cfg;
      if (load_pc) begin
        pc_ff <= vector_addr;
        calls_ff <= calls_ff + 32'h1;
      end
    end
  end
endmodule // fic_core_model

// File: four_level_interrupt_controller_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait apb, call walk of three cycles after the boundary
// Notes:   every check waits on a bounded loop
module four_level_interrupt_controller_tb;
  import fic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pa, pb, kr, step, rq, cq, ce;
  logic        pready, pslverr, il, ir, ic, call_req, push_pc, load_pc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, ncall;
  logic [15:0] hw_set, vector_addr, pc;
  logic [3:0]  in_service;
  int          n_fail, total_checks, i;
  fic_top dut_u (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin_a(pa), .ext_irq_pin_b(pb),
    .hw_set, .key_released(kr), .instr_last(il), .instr_reti(ir), .instr_cfg(ic),
    .call_req, .push_pc, .load_pc, .vector_addr, .in_service);
  fic_core_model core_u (.pclk, .presetn, .step, .reti_i(rq), .cfg_i(cq), .load_pc,
    .vector_addr, .instr_last(il), .instr_reti(ir), .instr_cfg(ic), .pc_ff(pc),
    .calls_ff(ncall));
  // -----------------------------------------------
  // tasks
  // -----------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      report_and_stop();
    end
    q = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic rs(input logic [3:0] e);
    xf(1'b0, OFS_STATUS, 32'h0);
    chk({28'h0, q[3:0]}, {28'h0, e});
    chk({28'h0, in_service}, {28'h0, e});
  endtask
  function automatic logic [15:0] vec(input int s);
    return VEC_BASE + VEC_STEP * 16'(s);
  endfunction
  // one instruction boundary; the call walk ends three cycles after it
  task automatic bnd(input logic r, input logic c, input logic e, input logic [15:0] v);
    logic [31:0] n0;
    n0 = ncall;
    @(posedge pclk);
    step <= 1'b1;
    rq <= r;
    cq <= c;
    @(posedge pclk);
    step <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(ncall - n0, {31'h0, e});
    if (e) chk({16'h0, pc}, {16'h0, v});
  endtask
  // -----------------------------------------------
  // clock, reset, stimulus
  // -----------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (50000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, step, rq, cq, kr} = 8'h00;
    {pa, pb} = 2'b11; // idle high, requests are low
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_set = 16'h0000;
    n_fail = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++) rc(8'(i * 4), 32'h0);
    wr(OFS_EN_A, 32'h32);
    wr(OFS_FLAGS, 32'h2);
    bnd(0, 0, 0, 0);
    wr(OFS_EN_A, 32'hB2);
    bnd(0, 1, 0, 0);
    bnd(0, 0, 0, 0);
    bnd(0, 0, 1, vec(1));
    rc(OFS_FLAGS, 32'h0);
    rs(4'h1);
    wr(OFS_PH_A, 32'h20);
    wr(OFS_FLAGS, 32'h30);
    bnd(0, 0, 1, vec(5));
    rs(4'h5);
    bnd(0, 0, 0, 0);
    rc(OFS_FLAGS, 32'h30);
    bnd(1, 0, 0, 0);
    rs(4'h1);
    bnd(0, 0, 0, 0);
    wr(OFS_PH_A, 32'h0);
    bnd(0, 0, 0, 0);
    bnd(1, 0, 0, 0);
    rs(4'h0);
    bnd(0, 0, 0, 0);
    bnd(0, 0, 1, vec(4));
    wr(OFS_FLAGS, 32'h0);
    bnd(1, 0, 0, 0);
    bnd(0, 0, 0, 0);
    bnd(0, 0, 0, 0);
    // edge mode on pin a, level mode on pin b
    wr(OFS_TRIG, 32'h1);
    wr(OFS_EN_A, 32'h85);
    @(posedge pclk) pa <= 1'b0;
    repeat (2) @(posedge pclk);
    pa <= 1'b1;
    rc(OFS_FLAGS, 32'h1);
    bnd(0, 0, 1, vec(0));
    rc(OFS_FLAGS, 32'h0);
    pb <= 1'b0;
    bnd(1, 0, 0, 0);
    bnd(0, 0, 0, 0);
    bnd(0, 0, 1, vec(2));
    rc(OFS_FLAGS, 32'h4);
    pb <= 1'b1;
    bnd(1, 0, 0, 0);
    bnd(0, 0, 0, 0);
    // peripheral set pulses that hardware clears on vectoring, then a key flag that key_released clears
    wr(OFS_EN_B, 32'h84);
    wr(OFS_EN_A, 32'h80);
    for (i = 0; i < 3; i++) begin
      @(posedge pclk) hw_set <= 16'h1 << ((i == 0) ? SRC_EE : (i == 1) ? SRC_CMP : SRC_WDT);
      @(posedge pclk) hw_set <= 16'h0000;
      bnd(0, 0, 1, vec((i == 0) ? SRC_EE : (i == 1) ? SRC_CMP : SRC_WDT));
      rc(OFS_FLAGS, 32'h0);
      bnd(1, 0, 0, 0);
      bnd(0, 0, 0, 0);
    end
    @(posedge pclk) hw_set <= 16'h0080;
    @(posedge pclk) hw_set <= 16'h0000;
    rc(OFS_FLAGS, 32'h80);
    kr <= 1'b1;
    rc(OFS_FLAGS, 32'h0);
    kr <= 1'b0;
    // top level: priority set while sources are disabled
    wr(OFS_PL_A, 32'h12);
    wr(OFS_PH_A, 32'h12);
    wr(OFS_EN_A, 32'h92);
    wr(OFS_FLAGS, 32'h12);
    bnd(0, 0, 1, vec(1));
    bnd(0, 0, 0, 0);
    rs(4'h8);
    // a frozen controller ignores a return boundary
    ce <= 1'b0;
    bnd(1, 0, 0, 0);
    ce <= 1'b1;
    rs(4'h8);
    report_and_stop();
  end
endmodule // four_level_interrupt_controller_tb
